// [hw/cdt_regfile.sv]
`timescale 1ns/1ps
// general registers: one registered read port, one byte-enabled write port
module cdt_regfile #(
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [AW-1:0] rd_addr,
   output logic [15:0] rd_data_r,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [1:0] wr_be,
   input wire logic [15:0] wr_data
);
   logic [15:0] mem [DEPTH];

   // one write enable per entry and lane
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (wr_en && wr_addr == AW'(i)) begin
            if (wr_be[1]) mem[i][15:8] <= wr_data[15:8];
            if (wr_be[0]) mem[i][7:0] <= wr_data[7:0];
         end
      end
   end

   // read data from a register, so a read costs one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) rd_data_r <= 16'h0000;
      else rd_data_r <= mem[rd_addr];
   end
endmodule : cdt_regfile

// [hw/cdt_xfer.sv]
`timescale 1ns/1ps
//Behaviour
//- move copies byte/word register-register, register-memory either way, or immediate
//- move accepts direct, indirect, displacement, abs16, immediate, predec, postinc both sizes
//- 8-bit absolute form exists for byte size only
//- peripheral store writes one byte synchronised to peripheral clock
//- peripheral load reads one byte synchronised to peripheral clock
//- push is word move with stack pointer predecremented before write
//- pop is word move reading at stack pointer then postincrementing
//- word accesses force address bit zero low, no error
module cdt_xfer
   import cdt_pkg::*;
#(
   parameter int PERIPH_DIV_P = cdt_pkg::PERIPH_DIV
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic INSTR_VALID,
   input wire logic [cdt_pkg::DATA_W-1:0] INSTR_DATA,
   output logic INSTR_READY,
   output logic [cdt_pkg::ADDR_W-1:0] MEM_ADDR,
   output logic [cdt_pkg::DATA_W-1:0] MEM_WDATA,
   input wire logic [cdt_pkg::DATA_W-1:0] MEM_RDATA,
   input wire logic MEM_ACK,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic MEM_WORD,
   output logic MEM_PERIPH,
   output logic PERIPH_CLK,
   output logic DONE,
   output logic ILLEGAL
);
   import cdt_pkg::*;

   cdt_state_e state_r;
   logic [15:0] ir_r, ext_r, base_r, wb_r, upd_r;
   logic [DIV_W-1:0] div_r;
   logic e_tick;
   logic [15:0] rf_rdata;
   logic [2:0] rf_raddr, rf_waddr;
   logic rf_we;
   logic [1:0] rf_be;
   logic [15:0] rf_wdata;

   // decode of the held first word
   logic [3:0] mode;
   logic size_w, dir_st, rn_lo, is_mem, is_load;
   logic [2:0] rm, rn;
   logic [15:0] step, ea, rn_byte;
   always_comb begin
      mode = ir_r[MODE_HI:MODE_LO];
      rm = ir_r[RM_LO +: 3];
      rn = ir_r[RN_LO +: 3];
      rn_lo = ir_r[HL_BIT];
      size_w = ir_r[SIZE_BIT];
      dir_st = ir_r[DIR_BIT];
      // short forms: bit 10 belongs to rn, so the store direction comes from its own operation code
      if (mode == MODE_ABS8 || mode == MODE_ABS8_ST || mode == MODE_IMM8) begin
         rn = ir_r[SHORT_RN_LO +: 3];
         rn_lo = ir_r[SHORT_HL_BIT];
         size_w = 1'b0;
         dir_st = (mode == MODE_ABS8_ST);
      end
      if (mode == MODE_PERIPH) size_w = 1'b0;
      if (mode == MODE_STACK) begin
         rm = SP_INDEX;
         size_w = 1'b1;
      end
      // byte step on the stack pointer would misalign it; code must avoid it
      step = size_w ? WORD_STEP : BYTE_STEP;
      is_mem = !(mode == MODE_REG || mode == MODE_IMM8 || mode == MODE_IMM16);
      is_load = !dir_st;
      // effective address per addressing mode
      case (mode)
         MODE_DISP: ea = base_r + ext_r;
         MODE_ABS16, MODE_PERIPH: ea = ext_r;
         MODE_ABS8, MODE_ABS8_ST: ea = {ABS8_PAGE, ir_r[7:0]};
         MODE_INCDEC, MODE_STACK: ea = dir_st ? base_r - step : base_r;
         default: ea = base_r;
      endcase
      if (size_w) ea = ea & EVEN_MASK;
      rn_byte = {8'h00, rn_lo ? rf_rdata[7:0] : rf_rdata[15:8]};
   end

   // legality and extension need of a word about to be taken
   function automatic logic legal_op(input logic [15:0] w);
      case (w[MODE_HI:MODE_LO])
         MODE_REG, MODE_IND, MODE_DISP, MODE_INCDEC, MODE_ABS16, MODE_IMM16,
         MODE_PERIPH, MODE_ABS8, MODE_ABS8_ST, MODE_IMM8, MODE_STACK: legal_op = 1'b1;
         default: legal_op = 1'b0;
      endcase
   endfunction : legal_op

   function automatic logic needs_ext(input logic [15:0] w);
      case (w[MODE_HI:MODE_LO])
         MODE_DISP, MODE_ABS16, MODE_IMM16, MODE_PERIPH: needs_ext = 1'b1;
         default: needs_ext = 1'b0;
      endcase
   endfunction : needs_ext

   // peripheral sync clock: divider gives one tick per period
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         div_r <= '0;
         PERIPH_CLK <= 1'b0;
      end else begin
         div_r <= (div_r == DIV_W'(PERIPH_DIV_P - 1)) ? '0 : div_r + 1'b1;
         PERIPH_CLK <= (div_r < DIV_W'(PERIPH_DIV_P / 2));
      end
   end
   assign e_tick = (div_r == '0);

   // register file port selection
   always_comb begin
      rf_raddr = (state_r == S_RDBASE) ? rm : rn;
      rf_we = (state_r == S_WB) || (state_r == S_UPD);
      rf_waddr = (state_r == S_UPD) ? rm : rn;
      rf_wdata = (state_r == S_UPD) ? upd_r : wb_r;
      if (state_r == S_WB && !size_w) begin
         rf_wdata = {wb_r[7:0], wb_r[7:0]};
         rf_be = rn_lo ? 2'b01 : 2'b10;
      end else begin
         rf_be = 2'b11;
      end
   end

   cdt_regfile #(.DEPTH(NUM_REGS), .AW(REG_IDX_W)) u_cdt_regfile (
      .clk(CORE_CLK),
      .rst(RST),
      .rd_addr(rf_raddr),
      .rd_data_r(rf_rdata),
      .wr_en(rf_we),
      .wr_addr(rf_waddr),
      .wr_be(rf_be),
      .wr_data(rf_wdata)
   );

   // sequencer: fetch, read base, read data, execute, bus, write back, update
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_r <= S_FETCH;
         ir_r <= ZERO_WORD;
         ext_r <= ZERO_WORD;
         base_r <= ZERO_WORD;
         wb_r <= ZERO_WORD;
         upd_r <= ZERO_WORD;
         INSTR_READY <= 1'b1;
         MEM_ADDR <= ZERO_WORD;
         MEM_WDATA <= ZERO_WORD;
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_WORD <= 1'b0;
         MEM_PERIPH <= 1'b0;
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
      end else begin
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         case (state_r)
            S_FETCH: if (INSTR_VALID) begin
               ir_r <= INSTR_DATA;
               if (!legal_op(INSTR_DATA)) begin
                  ILLEGAL <= 1'b1;
               end else if (needs_ext(INSTR_DATA)) begin
                  state_r <= S_EXT;
               end else begin
                  INSTR_READY <= 1'b0;
                  state_r <= S_RDBASE;
               end
            end
            S_EXT: if (INSTR_VALID) begin
               ext_r <= INSTR_DATA;
               INSTR_READY <= 1'b0;
               state_r <= S_RDBASE;
            end
            S_RDBASE: state_r <= S_RDDATA;
            S_RDDATA: begin
               base_r <= rf_rdata;
               state_r <= S_EXEC;
            end
            S_EXEC: begin
               // rf_rdata now holds the rn register
               MEM_ADDR <= ea;
               MEM_WORD <= size_w;
               MEM_WDATA <= size_w ? rf_rdata : rn_byte;
               upd_r <= dir_st ? base_r - step : base_r + step;
               case (mode)
                  MODE_REG: wb_r <= size_w ? base_r : {8'h00, rm[0] ? base_r[7:0] : base_r[15:8]};
                  MODE_IMM8: wb_r <= {8'h00, ir_r[7:0]};
                  MODE_IMM16: wb_r <= ext_r;
                  default: wb_r <= ZERO_WORD;
               endcase
               if (!is_mem) begin
                  state_r <= S_WB;
               end else if (mode == MODE_PERIPH) begin
                  state_r <= S_PER;
               end else begin
                  MEM_RD <= is_load;
                  MEM_WR <= dir_st;
                  state_r <= S_MEM;
               end
            end
            S_MEM: if (MEM_ACK) begin
               MEM_RD <= 1'b0;
               MEM_WR <= 1'b0;
               wb_r <= size_w ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};
               if (is_load) state_r <= S_WB;
               else if (mode == MODE_INCDEC || mode == MODE_STACK) state_r <= S_UPD;
               else begin
                  DONE <= 1'b1;
                  INSTR_READY <= 1'b1;
                  state_r <= S_FETCH;
               end
            end
            // the slow access opens on one tick and closes on the next
            S_PER: if (e_tick) begin
               MEM_PERIPH <= 1'b1;
               MEM_RD <= is_load;
               MEM_WR <= dir_st;
               state_r <= S_PACC;
            end
            S_PACC: if (e_tick) begin
               MEM_PERIPH <= 1'b0;
               MEM_RD <= 1'b0;
               MEM_WR <= 1'b0;
               wb_r <= {8'h00, MEM_RDATA[7:0]};
               if (is_load) state_r <= S_WB;
               else begin
                  DONE <= 1'b1;
                  INSTR_READY <= 1'b1;
                  state_r <= S_FETCH;
               end
            end
            S_WB: if (mode == MODE_INCDEC || mode == MODE_STACK) begin
               state_r <= S_UPD;
            end else begin
               DONE <= 1'b1;
               INSTR_READY <= 1'b1;
               state_r <= S_FETCH;
            end
            S_UPD: begin
               DONE <= 1'b1;
               INSTR_READY <= 1'b1;
               state_r <= S_FETCH;
            end
            default: state_r <= S_FETCH;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   AST_WORD_EVEN: assert property ((MEM_RD || MEM_WR) && MEM_WORD |-> MEM_ADDR[0] == 1'b0)
      else $error("word access at odd address");
   AST_PERIPH_ON_TICK: assert property ($rose(MEM_PERIPH) |-> $past(e_tick))
      else $error("peripheral access not opened on tick");
   AST_PERIPH_BYTE: assert property (MEM_PERIPH |-> !MEM_WORD)
      else $error("peripheral access not byte sized");
   AST_PERIPH_DIR: assert property (MEM_PERIPH && MEM_WR |-> ir_r[DIR_BIT])
      else $error("peripheral store with load direction");
   AST_PUSH_ADDR: assert property (MEM_WR && mode == MODE_STACK
      |-> MEM_ADDR == ((base_r - WORD_STEP) & EVEN_MASK))
      else $error("push not at predecremented stack pointer");
   AST_POP_UPD: assert property (state_r == S_UPD && mode == MODE_STACK && !dir_st
      |-> rf_waddr == SP_INDEX && rf_wdata == base_r + WORD_STEP)
      else $error("pop did not postincrement stack pointer");
   AST_ABS8_BYTE: assert property ((MEM_RD || MEM_WR) && (mode == MODE_ABS8 || mode == MODE_ABS8_ST)
      |-> !MEM_WORD && MEM_ADDR[15:8] == ABS8_PAGE)
      else $error("short absolute access malformed");
   AST_EXT_FETCH: assert property (state_r == S_FETCH && INSTR_VALID && legal_op(INSTR_DATA)
      |=> (state_r == S_EXT) == needs_ext(ir_r))
      else $error("extension word fetch mismatch");
   AST_MEM_OP: assert property ($rose(MEM_RD) && !MEM_PERIPH |-> ##[1:1000] !MEM_RD)
      else $error("memory read never closed");
   AST_SP_WORD: assert property ((MEM_RD || MEM_WR) && mode == MODE_STACK |-> MEM_WORD)
      else $error("stack access not word sized");

   COV_PUSH: cover property (MEM_WR && mode == MODE_STACK);
   COV_POP: cover property (state_r == S_UPD && mode == MODE_STACK && !dir_st);
   COV_PERIPH_LD: cover property (MEM_PERIPH && MEM_RD);
   COV_PERIPH_ST: cover property (MEM_PERIPH && MEM_WR);
endmodule : cdt_xfer

// [shared/cdt_pkg.sv]
package cdt_pkg;
   // datapath and register file shape
   localparam int DATA_W = 16;
   localparam int ADDR_W = 16;
   localparam int NUM_REGS = 8;
   localparam int REG_IDX_W = 3;
   // operation field of the first word, upper nibble of the upper byte
   localparam logic [3:0] MODE_REG = 4'h1;
   localparam logic [3:0] MODE_IND = 4'h2;
   localparam logic [3:0] MODE_DISP = 4'h3;
   localparam logic [3:0] MODE_INCDEC = 4'h4;
   localparam logic [3:0] MODE_ABS16 = 4'h5;
   localparam logic [3:0] MODE_IMM16 = 4'h6;
   localparam logic [3:0] MODE_PERIPH = 4'h7;
   localparam logic [3:0] MODE_ABS8 = 4'h8;
   localparam logic [3:0] MODE_IMM8 = 4'h9;
   localparam logic [3:0] MODE_STACK = 4'hA;
   // short absolute store: the short forms have no room for a direction bit
   localparam logic [3:0] MODE_ABS8_ST = 4'hB;
   // field positions in the first word
   localparam int MODE_HI = 15;
   localparam int MODE_LO = 12;
   localparam int SIZE_BIT = 11;
   localparam int DIR_BIT = 10;
   localparam int RM_LO = 4;
   localparam int RN_LO = 0;
   localparam int HL_BIT = 3;
   localparam int SHORT_RN_LO = 8;
   localparam int SHORT_HL_BIT = 11;
   // fixed values
   localparam logic [2:0] SP_INDEX = 3'h7;
   localparam logic [7:0] ABS8_PAGE = 8'hFF;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] EVEN_MASK = 16'hFFFE;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   // core clock cycles per peripheral sync clock period
   localparam int PERIPH_DIV = 10;
   localparam int DIV_W = 8;
   typedef enum logic [3:0] {
      S_FETCH, S_EXT, S_RDBASE, S_RDDATA, S_EXEC, S_MEM, S_PER, S_PACC, S_WB, S_UPD
   } cdt_state_e;
endpackage : cdt_pkg

// [tb/cdt_mem_model.sv]
`timescale 1ns/1ps
// behavioural memory and peripheral bus on the far side of the transfer block
module cdt_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ack_delay,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic rd,
   input wire logic wr,
   input wire logic word,
   input wire logic periph,
   output logic [15:0] rdata,
   output logic ack
);
   logic [7:0] mem [0:65535];
   logic [3:0] cnt_r;
   // normal cycles only; peripheral cycles are timed by the core, so no acknowledge there
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 4'h0;
         ack <= 1'b0;
      end else if ((rd || wr) && !periph && !ack && cnt_r != ack_delay) begin
         cnt_r <= cnt_r + 4'h1;
      end else begin
         ack <= (rd || wr) && !periph && !ack;
         cnt_r <= 4'h0;
      end
   end
   // data valid only while selected; otherwise it flips each cycle so stale data never matches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 16'hA5A5;
      end else if (rd) begin
         rdata <= word ? {mem[addr], mem[addr + 16'h0001]} : {~mem[addr], mem[addr]};
      end else begin
         rdata <= ~rdata;
      end
   end
   // big-endian words; plain always so the bench may preload bytes
   always @(posedge clk) begin
      if (wr && (ack || periph) && word) begin
         mem[addr] <= wdata[15:8];
         mem[addr + 16'h0001] <= wdata[7:0];
      end else if (wr && (ack || periph)) begin
         mem[addr] <= wdata[7:0];
      end
   end
endmodule : cdt_mem_model

// [tb/cdt_xfer_tb_top.sv]
`timescale 1ns/1ps
module cdt_xfer_tb_top;
   import cdt_pkg::*;
   localparam int DIV = 4;
   logic clk, rst, iv, ir, ack, rd, wr, wd, per, pclk, done, ill;
   logic [15:0] id, ma, mw, mr, last_addr;
   logic [3:0] dly;
   logic per_d = 1'b0;
   logic pclk_d = 1'b0;
   logic [1:0] pclk_open;
   logic last_word;
   int num_errors = 0;
   int samples_checked = 0;
   int per_cnt = 0;
   cdt_xfer #(.PERIPH_DIV_P(DIV)) u_cdt_xfer (.CORE_CLK(clk), .RST(rst), .INSTR_VALID(iv), .INSTR_DATA(id),
      .INSTR_READY(ir), .MEM_ADDR(ma), .MEM_WDATA(mw), .MEM_RDATA(mr), .MEM_ACK(ack), .MEM_RD(rd),
      .MEM_WR(wr), .MEM_WORD(wd), .MEM_PERIPH(per), .PERIPH_CLK(pclk), .DONE(done), .ILLEGAL(ill));
   cdt_mem_model u_cdt_mem_model (.clk(clk), .rst(rst), .ack_delay(dly), .addr(ma), .wdata(mw), .rd(rd),
      .wr(wr), .word(wd), .periph(per), .rdata(mr), .ack(ack));
   always #20 clk = ~clk;
   // bus monitor: last address seen and length of a synchronised access
   always @(posedge clk) begin
      if ((rd || wr) && per) per_cnt++;
      // peripheral clock level before and at the opening edge of a synchronised access
      if (per && !per_d) pclk_open = {pclk_d, pclk};
      per_d = per;
      pclk_d = pclk;
      if (rd || wr) begin
         last_addr = ma;
         last_word = wd;
      end
   end
   function automatic logic [15:0] memw(input logic [15:0] a);
      return {u_cdt_mem_model.mem[a], u_cdt_mem_model.mem[a + 16'h0001]};
   endfunction : memw
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   // wait for the edge that takes the offered word
   task automatic take;
      int n;
      n = 0;
      @(posedge clk);
      while (ir !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check({15'h0, ir}, 16'h0001);
   endtask : take
   // valid held across both words so it is never lowered and raised in one step
   task automatic exec(input logic [15:0] w, input logic [15:0] ext, input bit two);
      int n;
      n = 0;
      per_cnt = 0;
      pclk_open = 2'b00;
      iv <= 1'b1;
      id <= w;
      take;
      if (two) begin
         id <= ext;
         take;
      end
      iv <= 1'b0;
      id <= ~id;
      while (done !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      check({15'h0, done}, 16'h0001);
   endtask : exec
   task automatic t_move;
      exec(16'h6801, 16'h1234, 1);
      exec(16'h5C01, 16'h0040, 1);
      check(memw(16'h0040), 16'h1234);
      check(last_addr, 16'h0040);
      check({15'h0, last_word}, 16'h0001);
      exec(16'h1812, 16'h0000, 0);
      dly <= 4'h3;
      exec(16'h5C02, 16'h0051, 1);
      check(last_addr, 16'h0050);
      check(memw(16'h0050), 16'h1234);
      exec(16'h6804, 16'hAAAA, 1);
      exec(16'h9C5A, 16'h0000, 0);
      exec(16'h5C04, 16'h0060, 1);
      check(memw(16'h0060), 16'hAA5A);
      $display("test move finished");
   endtask : t_move
   task automatic t_stack;
      exec(16'h6807, 16'h0100, 1);
      exec(16'h3C71, 16'h0010, 1);
      check(memw(16'h0110), 16'h1234);
      // stack pointer forms are always issued at word size
      exec(16'hAC01, 16'h0000, 0);
      check(last_addr, 16'h00FE);
      check(memw(16'h00FE), 16'h1234);
      u_cdt_mem_model.mem[16'h00FE] = 8'hBE;
      u_cdt_mem_model.mem[16'h00FF] = 8'hEF;
      dly <= 4'h0;
      exec(16'hA803, 16'h0000, 0);
      check(last_addr, 16'h00FE);
      exec(16'h5C07, 16'h0070, 1);
      check(memw(16'h0070), 16'h0100);
      exec(16'h5C03, 16'h0072, 1);
      check(memw(16'h0072), 16'hBEEF);
      $display("test stack finished");
   endtask : t_stack
   task automatic t_periph;
      exec(16'h7409, 16'h0080, 1);
      check({8'h00, u_cdt_mem_model.mem[16'h0080]}, 16'h0034);
      check(16'(per_cnt), 16'(DIV));
      check({14'h0, pclk_open}, 16'h0001);
      check({15'h0, last_word}, 16'h0000);
      exec(16'h6805, 16'h0000, 1);
      u_cdt_mem_model.mem[16'h0081] = 8'hC3;
      exec(16'h700D, 16'h0081, 1);
      check(16'(per_cnt), 16'(DIV));
      check({14'h0, pclk_open}, 16'h0001);
      check({8'h00, u_cdt_mem_model.mem[16'h0081]}, 16'h00C3);
      exec(16'h5C05, 16'h0090, 1);
      check(memw(16'h0090), 16'h00C3);
      $display("test peripheral finished");
   endtask : t_periph
   // indirect load, predecrement store, postincrement load and short absolute forms in both directions
   task automatic t_modes;
      exec(16'h6806, 16'h0200, 1);
      exec(16'h4C61, 16'h0000, 0);
      check(last_addr, 16'h01FE);
      check(memw(16'h01FE), 16'h1234);
      exec(16'h406A, 16'h0000, 0);
      exec(16'h2863, 16'h0000, 0);
      check(last_addr, 16'h01FE);
      exec(16'h5C06, 16'h00A0, 1);
      check(memw(16'h00A0), 16'h01FF);
      exec(16'h5C02, 16'h00A2, 1);
      check(memw(16'h00A2), 16'h1212);
      exec(16'h5C03, 16'h00A4, 1);
      check(memw(16'h00A4), 16'h1234);
      exec(16'hBAB0, 16'h0000, 0);
      check(last_addr, 16'hFFB0);
      check({15'h0, last_word}, 16'h0000);
      check({8'h00, u_cdt_mem_model.mem[16'hFFB0]}, 16'h0012);
      exec(16'h85B0, 16'h0000, 0);
      exec(16'h5C05, 16'h00A6, 1);
      check(memw(16'h00A6), 16'h12C3);
      $display("test modes finished");
   endtask : t_modes
   task automatic t_illegal;
      logic seen;
      int i;
      seen = 1'b0;
      iv <= 1'b1;
      id <= 16'h0000;
      take;
      iv <= 1'b0;
      for (i = 0; i < 3; i++) begin
         @(posedge clk);
         if (ill === 1'b1) seen = 1'b1;
         check({15'h0, ir}, 16'h0001);
      end
      check({15'h0, seen}, 16'h0001);
      $display("test illegal finished");
   endtask : t_illegal
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      iv = 1'b0;
      id = 16'h0000;
      dly = 4'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_move;
      t_stack;
      t_periph;
      t_modes;
      t_illegal;
      finish_test;
   end
   // a few hundred cycles are expected; this allows about two hundred times that
   initial begin
      #2_000_000;
      num_errors++;
      $display("watchdog expired");
      finish_test;
   end
endmodule : cdt_xfer_tb_top
